// ==== rtl/eit_pkg.sv ====
/*
 * Constants shared by the eight-bit interval and event timer:
 * register indices, field positions, reset values and count constants.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
package eit_pkg;

	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_MODE_CTRL   = 16'hFF53; // Mode control
	localparam logic [15:0] IDX_MATCH       = 16'hFF50; // Match value
	localparam logic [15:0] IDX_COUNT       = 16'hFF51; // Event count
	localparam logic [15:0] IDX_P2_DIR      = 16'hFF52; // Port two direction
	localparam logic [15:0] IDX_P2_LATCH    = 16'hFF54; // Port two latch

	// Avalon address width in bits
	localparam int          ADDR_W          = 18;

	// Mode control field positions
	localparam int          BIT_RUN         = 7;  // Count run
	localparam int          BIT_PWM         = 6;  // Pulse width select
	localparam int          BIT_SRC_HI      = 2;  // Source select high
	localparam int          BIT_SRC_LO      = 1;  // Source select low
	localparam int          BIT_PIN_EN      = 0;  // Pin drive enable
	localparam logic [7:0]  MODE_WR_MASK    = 8'hC7; // Bits 5..3 reserved

	// Pin routed from the timer on port two
	localparam int          PIN_TIMER       = 4;

	// Reset values
	localparam logic [7:0]  RST_MODE_CTRL   = 8'h00;
	localparam logic [7:0]  RST_MATCH       = 8'h00;
	localparam logic [7:0]  RST_COUNT       = 8'h00;
	localparam logic [7:0]  RST_P2_DIR      = 8'hFF;
	localparam logic [7:0]  RST_P2_LATCH    = 8'h00;

	// Prescaler for the divided system clock source
	localparam int          PRESCALE_DIV    = 8;
	localparam logic [2:0]  PRESCALE_LAST   = 3'(PRESCALE_DIV - 1);

	// Count source encodings
	typedef enum logic [1:0] {
		EIT_SRC_CLK   = 2'h0,
		EIT_SRC_DIV8  = 2'h1,
		EIT_SRC_RISE  = 2'h2,
		EIT_SRC_FALL  = 2'h3
	} eit_src_t;

endpackage : eit_pkg

// ==== rtl/eit_edge_sync.sv ====
/*
 * Two-flop synchroniser for the event input followed by an edge
 * detector giving one-cycle rising and falling pulses.
 * Assumes the event input may change at any time relative to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module eit_edge_sync (
	input  wire logic sys_clk,   // System clock
	input  wire logic resetn,    // Synchronous reset, active low
	input  wire logic ce,        // Clock enable
	input  wire logic event_in,  // Raw event input
	output logic      rise_pulse, // One pulse per rising edge
	output logic      fall_pulse  // One pulse per falling edge
);

	logic meta_reg;    // First synchroniser stage
	logic meta_next;
	logic sync_reg;    // Second synchroniser stage
	logic sync_next;
	logic prev_reg;    // Delayed copy for edge detection
	logic prev_next;
	logic rise_reg;    // Registered rising pulse
	logic rise_next;
	logic fall_reg;    // Registered falling pulse
	logic fall_next;

	// Next values; only the second stage feeds the edge logic
	always_comb
	begin
		meta_next = event_in;
		sync_next = meta_reg;
		prev_next = sync_reg;
		rise_next = sync_reg & ~prev_reg;
		fall_next = ~sync_reg & prev_reg;
	end

	// Register stage
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
			rise_reg <= 1'b0;
			fall_reg <= 1'b0;
		end
		else if (ce)
		begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
			rise_reg <= rise_next;
			fall_reg <= fall_next;
		end
	end

	assign rise_pulse = rise_reg;
	assign fall_pulse = fall_reg;

endmodule : eit_edge_sync

`default_nettype wire

// ==== rtl/eit_timer.sv ====
/*
 * Eight-bit interval and event timer with its Avalon-MM register slave
 * and the port two direction and latch logic of the shared output pin.
 * Assumes a single sys_clk domain and an Avalon master that holds each
 * request until it samples waitrequest low.
 */
`timescale 1ns/1ps
`default_nettype none

module eit_timer (
	input  wire logic        sys_clk,             // System clock, 200 MHz
	input  wire logic        resetn,              // Sync reset, active low
	input  wire logic        ce,                  // Clock enable
	input  wire logic [17:0] avs_address,         // Byte address
	input  wire logic        avs_read,            // Read request
	input  wire logic        avs_write,           // Write request
	input  wire logic [31:0] avs_writedata,       // Write data
	input  wire logic [3:0]  avs_byteenable,      // Byte lanes
	output logic      [31:0] avs_readdata,        // Read data
	output logic             avs_waitrequest,     // Stall request
	input  wire logic        event_in,            // External event input
	input  wire logic [7:0]  port_two_in,         // Port two pin levels
	output logic      [7:0]  port_two_out,        // Port two pin drive
	output logic      [7:0]  port_two_oe,         // Port two enables
	output logic             toggle_out,          // Timer output level
	output logic             match_irq            // Match pulse
);

	// Register file
	logic [7:0]  mode_reg;      // Mode control
	logic [7:0]  mode_next;
	logic [7:0]  match_reg;     // Match value
	logic [7:0]  match_next;
	logic [7:0]  dir_reg;       // Port two direction
	logic [7:0]  dir_next;
	logic [7:0]  latch_reg;     // Port two output latch
	logic [7:0]  latch_next;

	// Bus slave state
	logic        wait_reg;      // Waitrequest
	logic        wait_next;
	logic [31:0] rdata_reg;     // Read data
	logic [31:0] rdata_next;

	// Timer state
	logic [7:0]  count_reg;     // Event count
	logic [7:0]  count_next;
	logic [2:0]  pre_reg;       // Prescaler
	logic [2:0]  pre_next;
	logic        tog_reg;       // Toggle output
	logic        tog_next;
	logic        irq_reg;       // Match interrupt pulse
	logic        irq_next;
	logic [7:0]  pout_reg;      // Pin drive levels
	logic [7:0]  pout_next;
	logic [7:0]  poe_reg;       // Pin enables
	logic [7:0]  poe_next;

	// Decoded controls
	logic        run;           // Count run
	logic        pwm_mode;      // Pulse width select
	logic        pin_en;        // Pin drive enable
	eit_pkg::eit_src_t src;     // Selected count source
	logic        tick;          // Count enable this cycle
	logic        rise_pulse;    // Synchronised rising edge
	logic        fall_pulse;    // Synchronised falling edge
	logic        wr_fire;       // Write accepted this cycle
	logic        rd_start;      // Read being answered
	logic [15:0] index;         // Word index from the address

	// Word index of a byte address
	function automatic logic [15:0] word_index(input logic [17:0] addr);
		word_index = addr[17:2];
	endfunction : word_index

	// Merge lane zero of a write into an eight-bit register
	function automatic logic [7:0] lane0(
		input logic [7:0]  old_val,
		input logic [31:0] wdata,
		input logic [3:0]  be
	);
		lane0 = be[0] ? wdata[7:0] : old_val;
	endfunction : lane0

	// Synchroniser and edge detector for the event input
	eit_edge_sync u_sync (
		.sys_clk    (sys_clk),
		.resetn     (resetn),
		.ce         (ce),
		.event_in   (event_in),
		.rise_pulse (rise_pulse),
		.fall_pulse (fall_pulse)
	);

	// Field decode of mode control
	assign run      = mode_reg[eit_pkg::BIT_RUN];
	assign pwm_mode = mode_reg[eit_pkg::BIT_PWM];
	assign pin_en   = mode_reg[eit_pkg::BIT_PIN_EN];
	assign src      = eit_pkg::eit_src_t'({mode_reg[eit_pkg::BIT_SRC_HI],
	                                       mode_reg[eit_pkg::BIT_SRC_LO]});
	assign index    = word_index(avs_address);
	assign wr_fire  = avs_write & ~wait_reg;
	assign rd_start = avs_read & wait_reg;

	// Count source selection
	always_comb
	begin
		tick = 1'b0;
		unique case (src)
			eit_pkg::EIT_SRC_CLK:  tick = 1'b1;
			eit_pkg::EIT_SRC_DIV8: tick = (pre_reg ==
			                              eit_pkg::PRESCALE_LAST);
			eit_pkg::EIT_SRC_RISE: tick = rise_pulse;
			eit_pkg::EIT_SRC_FALL: tick = fall_pulse;
		endcase
	end

	// Bus slave next values: one wait state, then answer
	always_comb
	begin
		wait_next  = 1'b1;
		rdata_next = rdata_reg;
		// Drop waitrequest one cycle after a request arrives
		if ((avs_read | avs_write) & wait_reg)
		begin
			wait_next = 1'b0;
		end
		// Capture read data while waiting; unmapped reads give zero
		if (rd_start)
		begin
			rdata_next = 32'h0000_0000;
			unique case (index)
				eit_pkg::IDX_MODE_CTRL:
					rdata_next[7:0] = mode_reg & eit_pkg::MODE_WR_MASK;
				eit_pkg::IDX_MATCH:
					rdata_next[7:0] = match_reg;
				eit_pkg::IDX_COUNT:
					rdata_next[7:0] = count_reg;
				eit_pkg::IDX_P2_DIR:
					rdata_next[7:0] = dir_reg;
				eit_pkg::IDX_P2_LATCH:
					rdata_next[7:0] = latch_reg;
				default:
					rdata_next = 32'h0000_0000;
			endcase
		end
	end

	// Register file next values; writes land at the answering edge
	always_comb
	begin
		mode_next  = mode_reg;
		match_next = match_reg;
		dir_next   = dir_reg;
		latch_next = latch_reg;
		if (wr_fire)
		begin
			unique case (index)
				// Reserved bits are dropped on write
				eit_pkg::IDX_MODE_CTRL:
					mode_next = lane0(mode_reg, avs_writedata, avs_byteenable)
					            & eit_pkg::MODE_WR_MASK;
				// Any byte value is a legal match value
				eit_pkg::IDX_MATCH:
					match_next = lane0(match_reg, avs_writedata,
					                   avs_byteenable);
				eit_pkg::IDX_P2_DIR:
					dir_next = lane0(dir_reg, avs_writedata,
					                 avs_byteenable);
				eit_pkg::IDX_P2_LATCH:
					latch_next = lane0(latch_reg, avs_writedata,
					                   avs_byteenable);
				// Event count is read only; unmapped writes vanish
				default:
					mode_next = mode_reg;
			endcase
		end
	end

	// Timer next values
	always_comb
	begin
		count_next = count_reg;
		pre_next   = pre_reg;
		tog_next   = tog_reg;
		irq_next   = 1'b0;
		if (!run)
		begin
			// Stopped: counter and output held low
			count_next = eit_pkg::RST_COUNT;
			pre_next   = 3'h0;
			tog_next   = 1'b0;
		end
		else
		begin
			// Prescaler runs only while counting
			pre_next = pre_reg + 3'h1;
			if (tick)
			begin
				if (count_reg == match_reg)
				begin
					// Match: interrupt, and restart from zero unless in PWM mode
					irq_next = 1'b1;
					// PWM mode lets the counter run on through a match
					count_next = pwm_mode ? count_reg + 8'h01
					                      : 8'h00;
					// Output inverts on each match when enabled
					if (pin_en)
					begin
						tog_next = ~tog_reg;
					end
				end
				else
				begin
					count_next = count_reg + 8'h01;
				end
			end
		end
		// Output starts low whenever drive is disabled
		if (!pin_en)
		begin
			tog_next = 1'b0;
		end
	end

	// Pin drive: timer output replaces the latch on its pin
	always_comb
	begin
		pout_next = latch_next;
		poe_next  = ~dir_next;
		if (mode_next[eit_pkg::BIT_PIN_EN])
		begin
			pout_next[eit_pkg::PIN_TIMER] = tog_next;
		end
	end

	// Register stage for all groups
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			mode_reg  <= eit_pkg::RST_MODE_CTRL;
			match_reg <= eit_pkg::RST_MATCH;
			dir_reg   <= eit_pkg::RST_P2_DIR;
			latch_reg <= eit_pkg::RST_P2_LATCH;
			wait_reg  <= 1'b1;
			rdata_reg <= 32'h0000_0000;
			count_reg <= eit_pkg::RST_COUNT;
			pre_reg   <= 3'h0;
			tog_reg   <= 1'b0;
			irq_reg   <= 1'b0;
			pout_reg  <= eit_pkg::RST_P2_LATCH;
			poe_reg   <= ~eit_pkg::RST_P2_DIR;
		end
		else if (ce)
		begin
			mode_reg  <= mode_next;
			match_reg <= match_next;
			dir_reg   <= dir_next;
			latch_reg <= latch_next;
			wait_reg  <= wait_next;
			rdata_reg <= rdata_next;
			count_reg <= count_next;
			pre_reg   <= pre_next;
			tog_reg   <= tog_next;
			irq_reg   <= irq_next;
			pout_reg  <= pout_next;
			poe_reg   <= poe_next;
		end
	end

	// Outputs straight from flip-flops
	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign toggle_out      = tog_reg;
	assign match_irq       = irq_reg;
	assign port_two_out    = pout_reg;
	assign port_two_oe     = poe_reg;

endmodule : eit_timer

`default_nettype wire

// ==== test/eit_timer_monitor.sv ====
/*
 * Port checker for the interval and event timer.
 * Assumes it is bound to eit_timer and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module eit_timer_monitor (
	input wire logic        sys_clk,         // System clock
	input wire logic        resetn,          // Sync reset, active low
	input wire logic        avs_read,        // Read request
	input wire logic        avs_write,       // Write request
	input wire logic [31:0] avs_readdata,    // Read data
	input wire logic        avs_waitrequest, // Stall
	input wire logic [7:0]  port_two_out,    // Pin drive
	input wire logic [7:0]  port_two_oe,     // Pin enables
	input wire logic        toggle_out,      // Timer output
	input wire logic        match_irq        // Match pulse
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// A taken request is answered on the next cycle
	wait_answer_a:
	assert property ((avs_read || avs_write) && avs_waitrequest |=>
		!avs_waitrequest) else $error("request not answered");
	// Answer lasts a single cycle
	wait_once_a:
	assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	// No answer without a request
	wait_idle_a:
	assert property (!(avs_read || avs_write) |=> avs_waitrequest)
		else $error("answer without request");
	// Registers are one byte wide
	rdata_high_a:
	assert property (avs_readdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	// Read data only moves on a read
	rdata_hold_a:
	assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data changed without read");
	// Outputs leave reset in their cleared state
	reset_out_a:
	assert property ($rose(resetn) |-> port_two_oe == 8'h00 &&
		port_two_out == 8'h00 && !match_irq && !toggle_out)
		else $error("outputs wrong after reset");
	// Output only rises on a match
	toggle_rise_a:
	assert property ($rose(toggle_out) |-> match_irq)
		else $error("toggle rose without match");
	// Output only falls on a match or within two cycles of any bus write
	toggle_fall_a:
	assert property ($fell(toggle_out) |-> match_irq ||
		$past(avs_write) || $past(avs_write, 2))
		else $error("toggle fell without cause");

	cover property (match_irq);
	cover property ($rose(toggle_out));
	cover property (avs_read && !avs_waitrequest);
endmodule : eit_timer_monitor

`default_nettype wire

// ==== test/test_eit_timer.sv ====
/*
 * Self-checking bench for the interval and event timer.
 * Assumes eit_pkg and eit_timer are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module test_eit_timer;
	logic        sys_clk;         // Clock
	logic        resetn;          // Reset, active low
	logic        ce;              // Clock enable
	logic [17:0] avs_address;     // Bus address
	logic        avs_read;        // Bus read
	logic        avs_write;       // Bus write
	logic [31:0] avs_writedata;   // Bus write data
	logic [3:0]  avs_byteenable;  // Bus lanes
	logic [31:0] avs_readdata;    // Bus read data
	logic        avs_waitrequest; // Bus stall
	logic        event_in;        // Event pin
	logic [7:0]  port_two_out;    // Pin drive
	logic [7:0]  port_two_oe;     // Pin enables
	logic        toggle_out;      // Timer output
	logic        match_irq;       // Match pulse
	logic [7:0]  q;               // Last read byte
	logic        t0;              // Saved output level
	int          mismatches;      // Failed checks
	int          check_count;     // All checks
	int          n;               // Measured period
	// Interval table: mode, match, period in cycles
	logic [7:0]  modes [4] = '{8'h01, 8'h00, 8'h03, 8'h41};
	logic [7:0]  marks [4] = '{8'h03, 8'hFF, 8'h01, 8'h02};
	int          spans [4] = '{4, 256, 16, 256};

	eit_timer eit_timer_i (
		.sys_clk(sys_clk), .resetn(resetn), .ce(ce),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .event_in(event_in),
		.port_two_in(8'h00), .port_two_out(port_two_out),
		.port_two_oe(port_two_oe), .toggle_out(toggle_out),
		.match_irq(match_irq)
	);

	// Free-running 200 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task test_done;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask : check

	task tick;
		@(posedge sys_clk);
		#1;
	endtask : tick

	// One bus cycle, held until waitrequest is seen low
	task bus(input logic w, input logic [15:0] idx, input logic [7:0] d);
		int i;
		@(posedge sys_clk);
		avs_address <= {idx, 2'b00};
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= {24'h0, d};
		i = 0;
		do
		begin
			@(posedge sys_clk);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 20);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (i >= 20)
		begin
			mismatches++;
			$display("wrong value at %0t: bus not answered", $time);
			test_done;
		end
	endtask : bus

	// Cycles between two match pulses, bounded
	task gap;
		int i;
		i = 0;
		n = 0;
		while (match_irq !== 1'b1 && i < 600)
		begin
			tick;
			i++;
		end
		do
		begin
			tick;
			n++;
		end while (match_irq !== 1'b1 && n < 600);
		if (i >= 600 || n >= 600)
		begin
			mismatches++;
			$display("wrong value at %0t: no match pulse", $time);
			test_done;
		end
	endtask : gap

	// Stop, pick source, load match, then run
	task start(input logic [7:0] m, input logic [7:0] v);
		bus(1'b1, eit_pkg::IDX_MODE_CTRL, 8'h00);
		bus(1'b1, eit_pkg::IDX_MODE_CTRL, m);
		bus(1'b1, eit_pkg::IDX_MATCH, v);
		bus(1'b1, eit_pkg::IDX_MODE_CTRL, m | 8'h80);
	endtask : start

	// Reset values, read-only and reserved places
	task reg_access;
		bus(1'b0, eit_pkg::IDX_MODE_CTRL, 8'h00);
		check(q, 8'h00);
		bus(1'b0, eit_pkg::IDX_COUNT, 8'h00);
		check(q, 8'h00);
		bus(1'b0, eit_pkg::IDX_P2_DIR, 8'h00);
		check(q, 8'hFF);
		check(port_two_oe, 8'h00);
		bus(1'b1, eit_pkg::IDX_MODE_CTRL, 8'h38);
		bus(1'b0, eit_pkg::IDX_MODE_CTRL, 8'h00);
		check(q, 8'h00);
		bus(1'b1, eit_pkg::IDX_COUNT, 8'h55);
		bus(1'b0, eit_pkg::IDX_COUNT, 8'h00);
		check(q, 8'h00);
		bus(1'b1, eit_pkg::IDX_MATCH, 8'hA5);
		bus(1'b0, eit_pkg::IDX_MATCH, 8'h00);
		check(q, 8'hA5);
		bus(1'b0, 16'h0001, 8'h00);
		check(q, 8'h00);
		bus(1'b1, eit_pkg::IDX_P2_DIR, 8'hEF);
		bus(1'b1, eit_pkg::IDX_P2_LATCH, 8'h00);
		tick;
		check(port_two_oe, 8'h10);
	endtask : reg_access

	// Periods and output toggling for the clock and divided sources and both modes
	task intervals;
		for (int k = 0; k < 4; k++)
		begin
			start(modes[k], marks[k]);
			gap;
			check(n, spans[k]);
			t0 = toggle_out;
			gap;
			check(toggle_out, modes[k][0] ? !t0 : 1'b0);
			check(port_two_out, {3'h0, modes[k][0] & !t0, 4'h0});
		end
		bus(1'b1, eit_pkg::IDX_MODE_CTRL, 8'h01);
		tick;
		tick;
		check(toggle_out, 1'b0);
		bus(1'b0, eit_pkg::IDX_COUNT, 8'h00);
		check(q, 8'h00);
	endtask : intervals

	// Clock enable low holds the running counter still
	task freeze;
		start(8'h00, 8'hFF);
		ce <= 1'b0;
		repeat (20) @(posedge sys_clk);
		ce <= 1'b1;
		bus(1'b0, eit_pkg::IDX_COUNT, 8'h00);
		check(q, 8'h01);
	endtask : freeze

	// Count match pulses over e pin pulses
	task events(input logic [7:0] m, input logic [7:0] v, input int e,
		input int exp);
		int c;
		c = 0;
		start(m, v);
		for (int k = 0; k < 8 * e + 8; k++)
		begin
			@(posedge sys_clk);
			event_in <= (k % 8 < 4) && (k < 8 * e);
			#1;
			c += (match_irq === 1'b1);
		end
		check(c, exp);
		check(toggle_out, 1'b0);
	endtask : events

	initial
	begin
		resetn = 1'b0;
		avs_address = 18'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h1;
		ce = 1'b1;
		event_in = 1'b0;
		mismatches = 0;
		check_count = 0;
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		reg_access;
		intervals;
		freeze;
		events(8'h04, 8'h01, 4, 2);
		events(8'h06, 8'h00, 3, 3);
		test_done;
	end
endmodule : test_eit_timer

bind eit_timer eit_timer_monitor eit_timer_monitor_i (
	.sys_clk(sys_clk), .resetn(resetn), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .port_two_out(port_two_out),
	.port_two_oe(port_two_oe), .toggle_out(toggle_out),
	.match_irq(match_irq)
);

`default_nettype wire
